// ---- hw/ea_bus_pkg.sv ----
// Purpose: Shared constants and types for address generation and the internal bus.
// Assumes: One clock, synchronous active-high reset.
// Notes: Address arithmetic is 24 bits wide; the bus carries the low 16 bits.
package ea_bus_pkg;

	localparam int ADDR_W = 16;
	localparam int FULL_W = 24;
	localparam int REG_W = 32;
	localparam logic [7:0] ABS8_UPPER = 8'hFF;
	localparam logic [15:0] IND_UPPER = 16'h0000;
	localparam logic [1:0] STATES_MEM = 2'h2;
	localparam logic [1:0] STATES_SLOW = 2'h3;
	localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
	localparam logic [31:0] STEP_WORD = 32'h0000_0002;
	localparam logic [31:0] STEP_LONG = 32'h0000_0004;

	typedef enum logic [3:0] {
		AM_REG = 4'h0,
		AM_IND = 4'h1,
		AM_DISP16 = 4'h2,
		AM_DISP24 = 4'h3,
		AM_POSTINC = 4'h4,
		AM_PREDEC = 4'h5,
		AM_ABS8 = 4'h6,
		AM_ABS16 = 4'h7,
		AM_ABS24 = 4'h8,
		AM_IMM = 4'h9,
		AM_PCREL8 = 4'hA,
		AM_PCREL16 = 4'hB,
		AM_MEMIND = 4'hC
	} addr_mode_e;

	typedef enum logic [1:0] {
		OP_ALU = 2'h0,
		OP_MOVE = 2'h1,
		OP_BIT = 2'h2,
		OP_BRANCH = 2'h3
	} op_class_e;

	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_WORD = 2'h1,
		SZ_LONG = 2'h2
	} op_size_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_T1 = 2'h1,
		ST_T2 = 2'h2,
		ST_T3 = 2'h3
	} bus_state_e;

endpackage : ea_bus_pkg

// ---- hw/int_bus_if.sv ----
// Purpose: Internal bus between the address generator and on-chip memory or registers.
// Assumes: Single clock; target answers with its width and state count combinationally.
// Notes: Strobes are active high and stand for the whole bus cycle.
interface int_bus_if;
	logic [15:0] addr;
	logic rd;
	logic wr;
	logic word;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic three_state;
	logic narrow;
	logic is_periph;

	modport master (output addr, output rd, output wr, output word, output wdata,
		input rdata, input three_state, input narrow, input is_periph);
	modport target (input addr, input rd, input wr, input word, input wdata,
		output rdata, output three_state, output narrow, output is_periph);
endinterface : int_bus_if

// ---- hw/ea_bus_master.sv ----
// Purpose: Effective address generation and internal bus cycle sequencing.
// Assumes: Register file and instruction decode live outside; one request at a time.
// Notes: Longword accesses run as two word cycles (four byte cycles to a narrow peripheral), high part first.
module ea_bus_master (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic enable_in,
	input wire logic req_in,
	input wire logic [1:0] op_class_in,
	input wire logic [3:0] mode_in,
	input wire logic [1:0] size_in,
	input wire logic write_in,
	input wire logic [3:0] reg_sel_in,
	input wire logic [31:0] reg_value_in,
	input wire logic [31:0] ext_in,
	input wire logic [23:0] pc_next_in,
	input wire logic [15:0] wdata_in,
	output logic busy_out,
	output logic done_out,
	output logic illegal_out,
	output logic [15:0] ea_out,
	output logic [31:0] data_out,
	output logic reg_wb_out,
	output logic [31:0] reg_wb_value_out,
	output logic [3:0] reg_wb_sel_out,
	output logic [23:0] branch_out,
	output logic branch_valid_out,
	output logic [2:0] bit_num_out,
	int_bus_if.master bus
);

	typedef struct packed {
		ea_bus_pkg::bus_state_e st;
		logic busy;
		logic done;
		logic illegal;
		logic [15:0] addr;
		logic rd;
		logic wr;
		logic word;
		logic [15:0] wdata;
		logic [1:0] parts_left;
		logic pointer;
		logic [31:0] data;
		logic wb;
		logic [31:0] wb_val;
		logic [3:0] wb_sel;
		logic [23:0] branch;
		logic bvalid;
		logic [2:0] bitn;
	} state_s;

	state_s cur_ff;
	state_s nxt_cur;

	function automatic logic mode_ok(input logic [1:0] cls, input logic [3:0] m);
		ea_bus_pkg::addr_mode_e am;
		am = ea_bus_pkg::addr_mode_e'(m);
		unique case (ea_bus_pkg::op_class_e'(cls))
			ea_bus_pkg::OP_ALU: mode_ok = (am == ea_bus_pkg::AM_REG) || (am == ea_bus_pkg::AM_IMM);
			ea_bus_pkg::OP_MOVE: mode_ok = (m <= 4'(ea_bus_pkg::AM_IMM));
			ea_bus_pkg::OP_BIT: mode_ok = (am == ea_bus_pkg::AM_REG) || (am == ea_bus_pkg::AM_IND)
				|| (am == ea_bus_pkg::AM_ABS8);
			ea_bus_pkg::OP_BRANCH: mode_ok = (am == ea_bus_pkg::AM_PCREL8)
				|| (am == ea_bus_pkg::AM_PCREL16) || (am == ea_bus_pkg::AM_MEMIND);
		endcase
	endfunction : mode_ok

	function automatic logic [31:0] step(input logic [1:0] sz);
		unique case (ea_bus_pkg::op_size_e'(sz))
			ea_bus_pkg::SZ_BYTE: step = ea_bus_pkg::STEP_BYTE;
			ea_bus_pkg::SZ_WORD: step = ea_bus_pkg::STEP_WORD;
			default: step = ea_bus_pkg::STEP_LONG;
		endcase
	endfunction : step

	always_comb begin
		logic [23:0] ea;
		logic [31:0] pre;
		logic is_mem;
		ea = '0;
		pre = reg_value_in - step(size_in);
		is_mem = 1'b0;
		nxt_cur = cur_ff;
		nxt_cur.done = 1'b0;
		nxt_cur.wb = 1'b0;
		nxt_cur.bvalid = 1'b0;
		unique case (ea_bus_pkg::addr_mode_e'(mode_in))
			ea_bus_pkg::AM_IND: ea = reg_value_in[23:0];
			ea_bus_pkg::AM_POSTINC: ea = reg_value_in[23:0];
			ea_bus_pkg::AM_PREDEC: ea = pre[23:0];
			ea_bus_pkg::AM_DISP16: ea = reg_value_in[23:0] + {{8{ext_in[15]}}, ext_in[15:0]};
			ea_bus_pkg::AM_DISP24: ea = reg_value_in[23:0] + ext_in[23:0];
			ea_bus_pkg::AM_ABS8: ea = {ea_bus_pkg::ABS8_UPPER, ea_bus_pkg::ABS8_UPPER, ext_in[7:0]};
			ea_bus_pkg::AM_ABS16: ea = {{8{ext_in[15]}}, ext_in[15:0]};
			ea_bus_pkg::AM_ABS24: ea = ext_in[23:0];
			ea_bus_pkg::AM_PCREL8: ea = pc_next_in + {{16{ext_in[7]}}, ext_in[7:0]};
			ea_bus_pkg::AM_PCREL16: ea = pc_next_in + {{8{ext_in[15]}}, ext_in[15:0]};
			ea_bus_pkg::AM_MEMIND: ea = {ea_bus_pkg::IND_UPPER, ext_in[7:0]};
			default: ea = '0;
		endcase
		is_mem = (mode_in != 4'(ea_bus_pkg::AM_REG)) && (mode_in != 4'(ea_bus_pkg::AM_IMM))
			&& (mode_in != 4'(ea_bus_pkg::AM_PCREL8)) && (mode_in != 4'(ea_bus_pkg::AM_PCREL16));
		unique case (cur_ff.st)
			ea_bus_pkg::ST_IDLE: begin
				if (req_in) begin
					nxt_cur.illegal = !mode_ok(op_class_in, mode_in);
					nxt_cur.addr = ea[15:0];
					nxt_cur.pointer = (mode_in == 4'(ea_bus_pkg::AM_MEMIND));
					nxt_cur.bitn = ext_in[2:0];
					nxt_cur.data = ext_in;
					nxt_cur.wb_sel = reg_sel_in;
					nxt_cur.wb_val = (mode_in == 4'(ea_bus_pkg::AM_PREDEC)) ? pre
						: reg_value_in + step(size_in);
					if (nxt_cur.illegal) begin
						nxt_cur.done = 1'b1;
					end else if (is_mem) begin
						nxt_cur.busy = 1'b1;
						nxt_cur.st = ea_bus_pkg::ST_T1;
						nxt_cur.rd = !write_in || nxt_cur.pointer;
						nxt_cur.wr = write_in && !nxt_cur.pointer;
						nxt_cur.wdata = wdata_in;
						nxt_cur.word = (size_in != 2'(ea_bus_pkg::SZ_BYTE)) || nxt_cur.pointer;
						nxt_cur.parts_left = (nxt_cur.pointer
							|| size_in == 2'(ea_bus_pkg::SZ_LONG)) ? 2'h1 : 2'h0;
						nxt_cur.data = '0;
					end else begin
						nxt_cur.done = 1'b1;
						nxt_cur.branch = ea;
						nxt_cur.bvalid = (mode_in == 4'(ea_bus_pkg::AM_PCREL8))
							|| (mode_in == 4'(ea_bus_pkg::AM_PCREL16));
					end
				end
			end
			ea_bus_pkg::ST_T1: begin
				nxt_cur.st = ea_bus_pkg::ST_T2;
				if (bus.is_periph && bus.narrow && cur_ff.word) begin
					nxt_cur.word = 1'b0;
					// Every word still owed becomes two bytes, so a longword ends as four.
					nxt_cur.parts_left = {cur_ff.parts_left[0], 1'b1};
				end
			end
			ea_bus_pkg::ST_T2, ea_bus_pkg::ST_T3: begin
				if (cur_ff.st == ea_bus_pkg::ST_T2 && bus.is_periph && bus.three_state) begin
					nxt_cur.st = ea_bus_pkg::ST_T3;
				end else begin
					nxt_cur.data = cur_ff.word ? {cur_ff.data[15:0], bus.rdata}
						: {cur_ff.data[23:0], bus.rdata[7:0]};
					if (cur_ff.parts_left != 2'h0) begin
						nxt_cur.parts_left = cur_ff.parts_left - 2'h1;
						nxt_cur.addr = cur_ff.addr + (cur_ff.word ? ea_bus_pkg::STEP_WORD[15:0]
							: ea_bus_pkg::STEP_BYTE[15:0]);
						nxt_cur.st = ea_bus_pkg::ST_T1;
					end else begin
						nxt_cur.st = ea_bus_pkg::ST_IDLE;
						nxt_cur.busy = 1'b0;
						nxt_cur.rd = 1'b0;
						nxt_cur.wr = 1'b0;
						nxt_cur.done = 1'b1;
						nxt_cur.wb = (mode_in == 4'(ea_bus_pkg::AM_POSTINC))
							|| (mode_in == 4'(ea_bus_pkg::AM_PREDEC));
						if (cur_ff.pointer) begin
							nxt_cur.branch = nxt_cur.data[23:0];
							nxt_cur.bvalid = 1'b1;
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			cur_ff <= '0;
		end else if (enable_in) begin
			cur_ff <= nxt_cur;
		end
	end

	assign busy_out = cur_ff.busy;
	assign done_out = cur_ff.done;
	assign illegal_out = cur_ff.illegal;
	assign ea_out = cur_ff.addr;
	assign data_out = cur_ff.data;
	assign reg_wb_out = cur_ff.wb;
	assign reg_wb_value_out = cur_ff.wb_val;
	assign reg_wb_sel_out = cur_ff.wb_sel;
	assign branch_out = cur_ff.branch;
	assign branch_valid_out = cur_ff.bvalid;
	assign bit_num_out = cur_ff.bitn;
	assign bus.addr = cur_ff.addr;
	assign bus.rd = cur_ff.rd;
	assign bus.wr = cur_ff.wr;
	assign bus.word = cur_ff.word;
	assign bus.wdata = cur_ff.wdata;

endmodule : ea_bus_master

// ---- hw/onchip_target.sv ----
// Purpose: Target end of the internal bus: memory and peripheral register window.
// Assumes: Peripheral window and its timing come from the user side as levels.
// Notes: Byte access to a 16-bit register is the only access flagged there; word access to an 8-bit register is split, not flagged.
module onchip_target (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic enable_in,
	input wire logic periph_in,
	input wire logic slow_in,
	input wire logic narrow_in,
	input wire logic [15:0] rdata_in,
	output logic [15:0] addr_out,
	output logic wr_out,
	output logic rd_out,
	output logic [15:0] wdata_out,
	output logic size_err_out,
	int_bus_if.target bus
);

	typedef struct packed {
		logic [15:0] addr;
		logic wr;
		logic rd;
		logic [15:0] wdata;
		logic err;
	} state_s;

	state_s cur_ff;
	state_s nxt_cur;

	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.addr = bus.addr;
		nxt_cur.rd = bus.rd;
		nxt_cur.wr = bus.wr;
		nxt_cur.wdata = bus.wdata;
		// A byte access to a 16-bit peripheral register is flagged and not written.
		nxt_cur.err = periph_in && !narrow_in && (bus.rd || bus.wr) && !bus.word;
		if (nxt_cur.err) begin
			nxt_cur.wr = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			cur_ff <= '0;
		end else if (enable_in) begin
			cur_ff <= nxt_cur;
		end
	end

	assign bus.rdata = rdata_in;
	assign bus.is_periph = periph_in;
	assign bus.three_state = slow_in;
	assign bus.narrow = narrow_in;
	assign addr_out = cur_ff.addr;
	assign wr_out = cur_ff.wr;
	assign rd_out = cur_ff.rd;
	assign wdata_out = cur_ff.wdata;
	assign size_err_out = cur_ff.err;

endmodule : onchip_target

// ---- sim/ea_bus_asserts.sv ----
// Purpose: Wire-level checks on the internal bus joining the two ends.
// Assumes: One clock, synchronous active-high reset.
// Notes: A bus cycle is seen as starting where a strobe rises.
module ea_bus_asserts (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic [15:0] addr,
	input wire logic rd,
	input wire logic wr,
	input wire logic word,
	input wire logic [15:0] wdata,
	input wire logic three_state,
	input wire logic narrow,
	input wire logic is_periph
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);
	sequence s_slow_start;
		$rose(rd) && is_periph && three_state;
	endsequence
	sequence s_hold_two;
		(rd && $stable(addr) && $stable(word))[*2];
	endsequence
	AST_RD_WR_EXCL: assert property (!(rd && wr))
		else $error("read and write strobes high together");
	AST_MEM_HOLD: assert property ($rose(rd) && !is_periph |=> rd && $stable(addr))
		else $error("memory cycle dropped its address early");
	AST_MEM_TWO: assert property ($rose(rd) && !is_periph |-> ##2 (!rd || $changed(addr)))
		else $error("memory cycle longer than two states");
	AST_SLOW_HOLD: assert property (s_slow_start |=> s_hold_two)
		else $error("slow cycle did not hold three states");
	AST_SLOW_END: assert property (s_slow_start |-> ##3 (!rd || $changed(addr)))
		else $error("slow cycle longer than three states");
	AST_WIDE_WORD: assert property ((rd || wr) && is_periph && !narrow |-> word)
		else $error("byte access to wide register");
	AST_WR_HOLD: assert property ($rose(wr) |=> wr && $stable(addr) && $stable(wdata))
		else $error("write cycle not held");
	AST_CYCLE_END: assert property ($rose(rd) |-> ##[2:16] !rd)
		else $error("read strobe never released");
	AST_RESET_IDLE: assert property (disable iff (1'b0) reset_in |=> !rd && !wr)
		else $error("strobe active after reset");
endmodule : ea_bus_asserts

// ---- sim/effective_address_and_bus_cycle_tb.sv ----
// Purpose: Drives both ends of the internal bus and checks addresses and state counts.
// Assumes: Target timing and width are set by level inputs held across each request.
// Notes: Narrow splits are assumed to step the address by one, high byte first.
module effective_address_and_bus_cycle_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_in = 1'b0;
	logic reset_in = 1'b1;
	logic req = 1'b0, wr = 1'b0, periph = 1'b0, slow = 1'b0, narrow = 1'b0;
	logic [1:0] cls = 2'h0, sz = 2'h0;
	logic [3:0] mode = 4'h0;
	logic [31:0] regv = 32'h0, ext = 32'h0, data;
	logic [23:0] pc = 24'h00_1000, br;
	logic [15:0] rdat = 16'hA5C3, ea, first_addr, last_addr;
	logic busy, done, illegal;
	logic [31:0] wbv;
	logic wb, bv;
	logic [2:0] bitn;
	logic [3:0] wsel;
	int err_count = 0, n_checks = 0, nbus;
	int_bus_if int_bus_if_i ();
	ea_bus_master ea_bus_master_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
		.enable_in(1'b1), .req_in(req), .op_class_in(cls), .mode_in(mode), .size_in(sz),
		.write_in(wr), .reg_sel_in(4'h3), .reg_value_in(regv), .ext_in(ext),
		.pc_next_in(pc), .wdata_in(ext[15:0]), .busy_out(busy), .done_out(done),
		.illegal_out(illegal), .ea_out(ea), .data_out(data), .reg_wb_out(wb),
		.reg_wb_value_out(wbv), .reg_wb_sel_out(wsel), .branch_out(br),
		.branch_valid_out(bv), .bit_num_out(bitn), .bus(int_bus_if_i));
	onchip_target onchip_target_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
		.enable_in(1'b1), .periph_in(periph), .slow_in(slow), .narrow_in(narrow),
		.rdata_in(rdat), .addr_out(), .wr_out(), .rd_out(), .wdata_out(),
		.size_err_out(), .bus(int_bus_if_i));
	ea_bus_asserts ea_bus_asserts_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
		.addr(int_bus_if_i.addr), .rd(int_bus_if_i.rd), .wr(int_bus_if_i.wr),
		.word(int_bus_if_i.word), .wdata(int_bus_if_i.wdata),
		.three_state(int_bus_if_i.three_state), .narrow(int_bus_if_i.narrow),
		.is_periph(int_bus_if_i.is_periph));
	always #10 clk_sys_in = ~clk_sys_in;
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// Counts strobe states so the cycle length is judged at the wire, not by done.
	task automatic run(input logic [1:0] c, input logic [3:0] m, input logic [1:0] s,
		input logic w, input logic [31:0] r, input logic [31:0] e);
		@(posedge clk_sys_in);
		cls <= c;
		mode <= m;
		sz <= s;
		wr <= w;
		regv <= r;
		ext <= e;
		req <= 1'b1;
		@(posedge clk_sys_in);
		req <= 1'b0;
		nbus = 0;
		for (int k = 0; k < 40 && done !== 1'b1; k++) begin
			@(posedge clk_sys_in);
			if (int_bus_if_i.rd === 1'b1 || int_bus_if_i.wr === 1'b1) begin
				nbus++;
				if (nbus == 1) begin
					first_addr = int_bus_if_i.addr;
					chk("busy", 32'h1, {31'h0, busy});
				end
				last_addr = int_bus_if_i.addr;
			end
		end
		if (done !== 1'b1) chk("done", 32'h1, 32'h0);
	endtask : run
	task automatic final_report;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : final_report
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	logic [3:0] tm [6] = '{4'h6, 4'h7, 4'h8, 4'h1, 4'h2, 4'h3};
	logic [31:0] tr [6] = '{32'h0, 32'h0, 32'h0, 32'h00AB_1234, 32'h0000_1000, 32'h00FF_0000};
	logic [31:0] te [6] = '{32'h42, 32'h8000, 32'h0012_3456, 32'h0, 32'hFFFE, 32'h0001_0010};
	logic [15:0] tx [6] = '{16'hFF42, 16'h8000, 16'h3456, 16'h1234, 16'h0FFE, 16'h0010};
	logic [7:0] tl [7] = '{8'h09, 8'h00, 8'h07, 8'h1A, 8'h1C, 8'h21, 8'h22};
	logic [6:0] tbad = 7'b0011101;
	initial begin
		repeat (12) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			run(2'h1, tm[i], 2'h1, 1'b0, tr[i], te[i]);
			chk("ea", {16'h0, tx[i]}, {16'h0, ea});
			chk("mem_states", 32'h2, nbus);
			chk("rdata", 32'hA5C3, {16'h0, data[15:0]});
		end
		for (int s = 0; s < 3; s++) begin
			run(2'h1, 4'h4, s[1:0], 1'b0, 32'h0001_2000, 32'h0);
			chk("post_wbp", 32'h1, {31'h0, wb});
			chk("wb_sel", 32'h3, {28'h0, wsel});
			chk("post_ea", 32'h2000, {16'h0, first_addr});
			chk("post_wb", 32'h0001_2000 + (32'h1 << s), wbv);
			chk("post_states", (s == 2) ? 32'h4 : 32'h2, nbus);
			run(2'h1, 4'h5, s[1:0], 1'b1, 32'h0001_2000, 32'h0);
			chk("pre_ea", 32'h2000 - (32'h1 << s), {16'h0, first_addr});
			chk("pre_wb", 32'h0001_2000 - (32'h1 << s), wbv);
		end
		for (int i = 0; i < 7; i++) begin
			run(tl[i][5:4], tl[i][3:0], 2'h0, 1'b0, 32'h3000, 32'h1234_567D);
			chk("illegal", {31'h0, tbad[6 - i]}, {31'h0, illegal});
			if (tbad[6 - i]) chk("no_bus", 32'h0, nbus);
			if (i == 0) chk("imm", 32'h1234_567D, data);
			if (i == 5) chk("bit_num", 32'h5, {29'h0, bitn});
		end
		pc <= 24'h01_0000;
		run(2'h3, 4'hA, 2'h0, 1'b0, 32'h0, 32'hFE);
		chk("pcrel8", 32'h00_FFFE, {8'h0, br});
		chk("br_valid", 32'h1, {31'h0, bv});
		run(2'h3, 4'hB, 2'h0, 1'b0, 32'h0, 32'h8000);
		chk("pcrel16", 32'h00_8000, {8'h0, br});
		run(2'h3, 4'hC, 2'h2, 1'b0, 32'h0, 32'h10);
		chk("memind_addr", 32'h10, {16'h0, first_addr});
		chk("memind_br", 32'h00C3_A5C3, {8'h0, br});
		chk("memind_valid", 32'h1, {31'h0, bv});
		periph <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			slow <= i[0];
			narrow <= i[1];
			run(2'h1, 4'h7, 2'h1, i[1], 32'h0, 32'hFF80);
			chk("periph_states", (i[1] ? 2 : 1) * (i[0] ? 3 : 2), nbus);
			chk("periph_last", i[1] ? 32'hFF81 : 32'hFF80, {16'h0, last_addr});
		end
		final_report();
	end
	initial begin
		#200us;
		err_count++;
		final_report();
	end
endmodule : effective_address_and_bus_cycle_tb
